// ==== common/sprt_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register address, 16-bit register data
// Notes:   included by its bare name
`ifndef SPRT_CONSTS_SVH
`define SPRT_CONSTS_SVH
// ==========================================
// register offsets
`define SPRT_A_CFGA   8'h00
`define SPRT_A_CFGB   8'h04
`define SPRT_A_CTRL   8'h08
`define SPRT_A_INTSP  8'h0C
`define SPRT_A_INTOFF 8'h10
`define SPRT_A_GRUP   8'h14
`define SPRT_A_GRDN   8'h18
`define SPRT_A_GRB2   8'h1C
`define SPRT_A_B2SP   8'h20
`define SPRT_A_RATK   8'h24
`define SPRT_A_STOI   8'h28
`define SPRT_A_EFF    8'h2C
`define SPRT_A_DEV    8'h30
`define SPRT_A_STAT   8'h34
`define SPRT_A_PV     8'h38
// ==========================================
// field positions
`define SPRT_F_EXTMSK 3:0
`define SPRT_F_EXTIN  5:4
`define SPRT_F_OFFMUL 6
`define SPRT_F_OFFEXT 7
`define SPRT_F_TRKPV  8
`define SPRT_F_LIM    10:9
`define SPRT_F_RATIO  11
`define SPRT_F_OFFMSK 4:0
`define SPRT_F_TRKMSK 8:5
`define SPRT_F_B2MSK  13:9
// ==========================================
// reset values
`define SPRT_R_ZERO   16'h0000
`define SPRT_R_STOI   16'h0100
`define SPRT_GRAD_OFF 16'h0000
// ==========================================
// timing
`define SPRT_CLK_NS    32'h0000_0032
`define SPRT_SAMPLE_NS 32'h0001_86A0
`define SPRT_TICK_CYC  (`SPRT_SAMPLE_NS / `SPRT_CLK_NS)
`endif

// ==== common/sprt_pkg.sv ====
// Purpose: types shared by the set-point block
// Assumes: constants live in sprt_consts.svh
// Notes:   no numbers besides encodings
package sprt_pkg;
	// ==========================================
	// front panel requests
	typedef struct packed {
		logic ext;
		logic off;
		logic trk;
		logic b2;
	} sprt_front_s;
	// ==========================================
	// digital control contacts
	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic d;
	} sprt_di_s;
	// ==========================================
	// min/max selection
	typedef enum logic [1:0] {
		SPRT_LIM_OFF = 2'h0,
		SPRT_LIM_MIN = 2'h1,
		SPRT_LIM_MAX = 2'h2
	} sprt_lim_e;
endpackage : sprt_pkg

// ==== rtl/sprt_top.sv ====
// Purpose: set-point select, offset, ramp, tracking, clamp, deviation
// Assumes: inputs synchronous to clock; values signed 16 bit, Q8.8 factors
// Notes:   ramp advances on an internal sample tick
`timescale 1ns/1ps
`include "sprt_consts.svh"
module sprt_top (
	input  wire logic                  clock,
	input  wire logic                  nrst,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [15:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [15:0]           reg_rdata,
	input  wire logic signed [15:0]    primary_analog_input,
	input  wire logic signed [15:0]    second_flow_input,
	input  wire logic signed [15:0]    limit_analog_input,
	input  wire logic signed [15:0]    isolated_analog_input,
	input  wire logic signed [15:0]    default_setpoint_input,
	input  wire logic signed [15:0]    position_feedback_input,
	input  wire logic signed [15:0]    external_offset,
	input  wire logic signed [15:0]    programmer_setpoint,
	input  wire logic                  programmer_active,
	input  wire sprt_pkg::sprt_front_s front_panel,
	input  wire sprt_pkg::sprt_di_s    control_inputs,
	output logic signed [15:0]         effective_setpoint,
	output logic signed [15:0]         control_deviation,
	output logic signed [15:0]         process_value,
	output logic                       ext_active,
	output logic                       offset_active,
	output logic                       bumpless_active,
	output logic                       backup_active,
	output logic                       ramping
);
	// ==========================================
	// state
	logic        [15:0] cfga_q, cfga_d, cfgb_q, cfgb_d, ctrl_q, ctrl_d;
	logic signed [15:0] intsp_q, intsp_d, intoff_q, intoff_d;
	logic        [15:0] grup_q, grup_d, grdn_q, grdn_d, grb2_q, grb2_d;
	logic signed [15:0] b2sp_q, b2sp_d, ratk_q, ratk_d, stoi_q, stoi_d;
	logic signed [15:0] ramp_q, ramp_d, eff_q, eff_d, dev_q, dev_d;
	logic signed [15:0] pv_q, pv_d;
	logic        [15:0] rdata_q, rdata_d;
	logic        [10:0] cnt_q, cnt_d;
	logic               tick_q, tick_d;
	logic               ext_q, ext_d, off_q, off_d, bump_q, bump_d;
	logic               b2_q, b2_d, prog_q, prog_d;
	logic               pend_q, pend_d, b2r_q, b2r_d, ramping_q, ramping_d;
	// ==========================================
	// combinational helpers
	logic        [3:0]  ext_src, trk_src;
	logic        [4:0]  off_src, b2_src;
	logic signed [15:0] ext_in, off_val, base, target;
	logic signed [31:0] prod, ws, xf;
	logic signed [16:0] diff, absd;
	logic        [15:0] grad;
	logic               copy, swchg;
	sprt_pkg::sprt_lim_e lim;

	assign reg_rdata          = rdata_q;
	assign effective_setpoint = eff_q;
	assign control_deviation  = dev_q;
	assign process_value      = pv_q;
	assign ext_active         = ext_q;
	assign offset_active      = off_q;
	assign bumpless_active    = bump_q;
	assign backup_active      = b2_q;
	assign ramping            = ramping_q;

	always_comb begin
		// defaults hold the software registers and ramp state
		cfga_d = cfga_q;
		cfgb_d = cfgb_q;
		ctrl_d = ctrl_q;
		intsp_d = intsp_q;
		intoff_d = intoff_q;
		grup_d = grup_q;
		grdn_d = grdn_q;
		grb2_d = grb2_q;
		b2sp_d = b2sp_q;
		ratk_d = ratk_q;
		stoi_d = stoi_q;
		ramp_d = ramp_q;
		pend_d = pend_q;
		b2r_d = b2r_q;
		// ==========================================
		// sample tick divider
		tick_d = (cnt_q == 11'(`SPRT_TICK_CYC - 1));
		cnt_d  = tick_d ? 11'h000 : 11'(cnt_q + 11'h001);
		// ==========================================
		// source priority
		ext_src = {control_inputs.b, control_inputs.a, front_panel.ext, ctrl_q[0]};
		// every enabled source must ask for external; one internal wins
		ext_d   = (cfga_q[`SPRT_F_EXTMSK] != 4'h0)
		          && ((ext_src | ~cfga_q[`SPRT_F_EXTMSK]) == 4'hF);
		off_src = {control_inputs.c, control_inputs.b, control_inputs.a,
		           front_panel.off, ctrl_q[1]};
		off_d   = |(off_src & cfgb_q[`SPRT_F_OFFMSK]);
		trk_src = {control_inputs.d, control_inputs.b, front_panel.trk, ctrl_q[2]};
		// only the type of switch-over is stored, no source is chosen here
		bump_d  = |(trk_src & cfgb_q[`SPRT_F_TRKMSK]);
		b2_src  = {control_inputs.d, control_inputs.b, control_inputs.a,
		           front_panel.b2, ctrl_q[3]};
		b2_d    = |(b2_src & cfgb_q[`SPRT_F_B2MSK]);
		prog_d  = programmer_active;
		pv_d    = primary_analog_input;
		// ==========================================
		// target forming
		case (cfga_q[`SPRT_F_EXTIN])
			2'h1:    ext_in = isolated_analog_input;
			2'h2:    ext_in = position_feedback_input;
			default: ext_in = default_setpoint_input;
		endcase
		if (b2_q) begin
			base = b2sp_q;
		end else if (!ext_q) begin
			base = intsp_q;
		end else if (prog_q) begin
			base = programmer_setpoint;
		end else begin
			base = ext_in;
		end
		off_val = cfga_q[`SPRT_F_OFFEXT] ? external_offset : intoff_q;
		prod    = base * off_val;
		if (b2_q || !off_q) begin
			target = base;
		end else if (cfga_q[`SPRT_F_OFFMUL]) begin
			target = prod[23:8];
		end else begin
			target = 16'(base + off_val);
		end
		// ==========================================
		// ramp
		diff = {target[15], target} - {ramp_q[15], ramp_q};
		absd = diff[16] ? 17'(-diff) : diff;
		if (b2r_q) begin
			grad = grb2_q;
		end else begin
			grad = diff[16] ? grdn_q : grup_q;
		end
		if (tick_q) begin
			if (pend_q) begin
				// no range limit applied to the start value
				ramp_d = pv_q;
				pend_d = 1'b0;
			end else if (grad == `SPRT_GRAD_OFF || absd <= {1'b0, grad}) begin
				ramp_d = target;
				b2r_d  = 1'b0;
			end else if (diff[16]) begin
				ramp_d = ramp_q - grad;
			end else begin
				ramp_d = ramp_q + grad;
			end
		end
		ramping_d = (ramp_d != target) || pend_d;
		// ==========================================
		// switch-over handling, set wins over the tick clear
		swchg = (ext_d != ext_q) || (b2_d != b2_q) || (prog_d != prog_q);
		copy  = bump_q && !cfga_q[`SPRT_F_TRKPV] && ext_q && !ext_d && !b2_q;
		if (b2_d != b2_q) begin
			b2r_d = 1'b1;
		end
		if (swchg && !copy) begin
			pend_d = 1'b1;
		end
		// ==========================================
		// register writes
		if (reg_wr) begin
			case (reg_addr)
				`SPRT_A_CFGA:   cfga_d   = reg_wdata;
				`SPRT_A_CFGB:   cfgb_d   = reg_wdata;
				`SPRT_A_CTRL:   ctrl_d   = {12'h000, reg_wdata[3:0]};
				`SPRT_A_INTSP:  intsp_d  = reg_wdata;
				`SPRT_A_INTOFF: intoff_d = reg_wdata;
				`SPRT_A_GRUP:   grup_d   = reg_wdata;
				`SPRT_A_GRDN:   grdn_d   = reg_wdata;
				`SPRT_A_GRB2:   grb2_d   = reg_wdata;
				`SPRT_A_B2SP:   b2sp_d   = reg_wdata;
				`SPRT_A_RATK:   ratk_d   = reg_wdata;
				`SPRT_A_STOI:   stoi_d   = reg_wdata;
				default:        ;
			endcase
		end
		// tracking copy beats a software write in the same cycle
		if (copy) begin
			intsp_d = ramp_q;
		end
		// ==========================================
		// clamp and deviation
		lim = sprt_pkg::sprt_lim_e'(cfga_q[`SPRT_F_LIM]);
		case (lim)
			sprt_pkg::SPRT_LIM_MIN:
				eff_d = (ramp_q < limit_analog_input) ? limit_analog_input : ramp_q;
			sprt_pkg::SPRT_LIM_MAX:
				eff_d = (ramp_q > limit_analog_input) ? limit_analog_input : ramp_q;
			default:
				eff_d = ramp_q;
		endcase
		ws = eff_q * stoi_q;
		// the scaled product keeps its sign into the second multiply
		xf = $signed(ws[23:8]) * second_flow_input;
		if (cfga_q[`SPRT_F_RATIO]) begin
			dev_d = 16'(pv_q + ratk_q - xf[23:8]);
		end else begin
			dev_d = 16'(pv_q - eff_q);
		end
		// ==========================================
		// register reads, data valid only the cycle after the strobe
		rdata_d = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`SPRT_A_CFGA:   rdata_d = cfga_q;
				`SPRT_A_CFGB:   rdata_d = cfgb_q;
				`SPRT_A_CTRL:   rdata_d = ctrl_q;
				`SPRT_A_INTSP:  rdata_d = intsp_q;
				`SPRT_A_INTOFF: rdata_d = intoff_q;
				`SPRT_A_GRUP:   rdata_d = grup_q;
				`SPRT_A_GRDN:   rdata_d = grdn_q;
				`SPRT_A_GRB2:   rdata_d = grb2_q;
				`SPRT_A_B2SP:   rdata_d = b2sp_q;
				`SPRT_A_RATK:   rdata_d = ratk_q;
				`SPRT_A_STOI:   rdata_d = stoi_q;
				`SPRT_A_EFF:    rdata_d = eff_q;
				`SPRT_A_DEV:    rdata_d = dev_q;
				`SPRT_A_STAT:   rdata_d = {10'h000, pend_q, ramping_q, b2_q,
				                           bump_q, off_q, ext_q};
				`SPRT_A_PV:     rdata_d = pv_q;
				default:        rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cfga_q <= `SPRT_R_ZERO;
			cfgb_q <= `SPRT_R_ZERO;
			ctrl_q <= `SPRT_R_ZERO;
			intsp_q <= `SPRT_R_ZERO;
			intoff_q <= `SPRT_R_ZERO;
			grup_q <= `SPRT_GRAD_OFF;
			grdn_q <= `SPRT_GRAD_OFF;
			grb2_q <= `SPRT_GRAD_OFF;
			b2sp_q <= `SPRT_R_ZERO;
			ratk_q <= `SPRT_R_ZERO;
			stoi_q <= `SPRT_R_STOI;
			ramp_q <= `SPRT_R_ZERO;
			eff_q <= `SPRT_R_ZERO;
			dev_q <= `SPRT_R_ZERO;
			pv_q <= `SPRT_R_ZERO;
			rdata_q <= `SPRT_R_ZERO;
			cnt_q <= 11'h000;
			tick_q <= 1'b0;
			ext_q <= 1'b0;
			off_q <= 1'b0;
			bump_q <= 1'b0;
			b2_q <= 1'b0;
			prog_q <= 1'b0;
			// power-on counts as a switch-over
			pend_q <= 1'b1;
			b2r_q <= 1'b0;
			ramping_q <= 1'b0;
		end else begin
			cfga_q <= cfga_d;
			cfgb_q <= cfgb_d;
			ctrl_q <= ctrl_d;
			intsp_q <= intsp_d;
			intoff_q <= intoff_d;
			grup_q <= grup_d;
			grdn_q <= grdn_d;
			grb2_q <= grb2_d;
			b2sp_q <= b2sp_d;
			ratk_q <= ratk_d;
			stoi_q <= stoi_d;
			ramp_q <= ramp_d;
			eff_q <= eff_d;
			dev_q <= dev_d;
			pv_q <= pv_d;
			rdata_q <= rdata_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
			ext_q <= ext_d;
			off_q <= off_d;
			bump_q <= bump_d;
			b2_q <= b2_d;
			prog_q <= prog_d;
			pend_q <= pend_d;
			b2r_q <= b2r_d;
			ramping_q <= ramping_d;
		end
	end

	// ==========================================
	// checks
	chk_int_priority: assert property (@(posedge clock) disable iff (!nrst)
		(|(~ext_src & cfga_q[`SPRT_F_EXTMSK])) |=> !ext_q)
		else $error("internal request did not override external");
	chk_ext_select: assert property (@(posedge clock) disable iff (!nrst)
		(cfga_q[`SPRT_F_EXTMSK] != 4'h0 && (ext_src | ~cfga_q[`SPRT_F_EXTMSK]) == 4'hF)
		|=> ext_q)
		else $error("external set-point not selected");
	chk_offset_prio: assert property (@(posedge clock) disable iff (!nrst)
		(|(off_src & cfgb_q[`SPRT_F_OFFMSK])) |=> off_q)
		else $error("offset request lost");
	chk_backup_prio: assert property (@(posedge clock) disable iff (!nrst)
		b2_q |-> (base == b2sp_q))
		else $error("backup set-point not in force");
	chk_ramp_step: assert property (@(posedge clock) disable iff (!nrst)
		(tick_q && !pend_q && grad != `SPRT_GRAD_OFF) |=>
		(ramp_q == $past(target) || ramp_q == 16'($past(ramp_q) + $past(grad))
		 || ramp_q == 16'($past(ramp_q) - $past(grad))))
		else $error("ramp moved by more than one step");
	chk_ramp_off: assert property (@(posedge clock) disable iff (!nrst)
		(tick_q && !pend_q && grad == `SPRT_GRAD_OFF) |=> ramp_q == $past(target))
		else $error("gradient off did not step");
	chk_pv_load: assert property (@(posedge clock) disable iff (!nrst)
		(tick_q && pend_q) |=> (ramp_q == $past(pv_q) && !pend_q) or (pend_q && $past(swchg)))
		else $error("ramp did not start at process value");
	chk_track_copy: assert property (@(posedge clock) disable iff (!nrst)
		copy |=> intsp_q == $past(ramp_q))
		else $error("tracking copy missing");
	chk_clamp_min: assert property (@(posedge clock) disable iff (!nrst)
		(cfga_q[`SPRT_F_LIM] == 2'h1) |=> eff_q >= $past(limit_analog_input))
		else $error("effective set-point below limit");
	chk_clamp_max: assert property (@(posedge clock) disable iff (!nrst)
		(cfga_q[`SPRT_F_LIM] == 2'h2) |=> eff_q <= $past(limit_analog_input))
		else $error("effective set-point above limit");
	chk_eff_follow: assert property (@(posedge clock) disable iff (!nrst)
		(cfga_q[`SPRT_F_LIM] == 2'h0) |=> eff_q == $past(ramp_q))
		else $error("unclamped set-point differs from ramp");
	chk_offset_drop: assert property (@(posedge clock) disable iff (!nrst)
		((off_src & cfgb_q[`SPRT_F_OFFMSK]) == 5'h00) |=> !off_q)
		else $error("offset kept without request");
	chk_bump_level: assert property (@(posedge clock) disable iff (!nrst)
		(|(trk_src & cfgb_q[`SPRT_F_TRKMSK])) |=> bump_q)
		else $error("bumpless request lost");
	chk_backup_level: assert property (@(posedge clock) disable iff (!nrst)
		(|(b2_src & cfgb_q[`SPRT_F_B2MSK])) |=> b2_q)
		else $error("backup request lost");
	chk_pv_follow: assert property (@(posedge clock) disable iff (!nrst)
		1'b1 |=> pv_q == $past(primary_analog_input))
		else $error("process value not from primary input");
	chk_std_dev: assert property (@(posedge clock) disable iff (!nrst)
		!cfga_q[`SPRT_F_RATIO] |=> dev_q == 16'($past(pv_q) - $past(eff_q)))
		else $error("standard deviation wrong");
	chk_ramp_hold: assert property (@(posedge clock) disable iff (!nrst)
		!tick_q |=> ramp_q == $past(ramp_q))
		else $error("ramp moved between ticks");
	chk_tick_single: assert property (@(posedge clock) disable iff (!nrst)
		tick_q |=> !tick_q)
		else $error("sample tick longer than one cycle");
	chk_backup_grad: assert property (@(posedge clock) disable iff (!nrst)
		(tick_q && !pend_q && b2r_q && grb2_q != `SPRT_GRAD_OFF && absd > {1'b0, grb2_q}) |=>
		(ramp_q == 16'($past(ramp_q) + $past(grb2_q))
		 || ramp_q == 16'($past(ramp_q) - $past(grb2_q))))
		else $error("backup ramp not on its own gradient");
endmodule : sprt_top

// ==== verif/sprt_plant_model.sv ====
// Purpose: far side of the set-point block: plant inputs, panel keys, contacts
// Assumes: levels only; every change lands by non-blocking assignment after an edge
// Notes:   contacts hold their level until told otherwise, like a wired switch
`timescale 1ns/1ps
module sprt_plant_model (
	input  wire logic                  clock,
	output logic signed [15:0]         pv,
	output logic signed [15:0]         x2,
	output logic signed [15:0]         lim,
	output logic signed [15:0]         iso,
	output logic signed [15:0]         dflt,
	output logic signed [15:0]         pos,
	output logic signed [15:0]         eoff,
	output logic signed [15:0]         prog,
	output logic                       prog_act,
	output sprt_pkg::sprt_front_s      front,
	output sprt_pkg::sprt_di_s         di
);
	// ==========================================
	// start-up levels
	initial begin
		{pv, x2, lim, iso, dflt, pos, eoff, prog} = {8{16'h0000}};
		prog_act = 1'b0;
		front = 4'h0;
		di = 4'h0;
	end
	// ==========================================
	// one level change per call, taken right after an edge
	task put(input int sel, input logic [15:0] v);
		@(posedge clock);
		case (sel)
			0: pv <= v;
			1: x2 <= v;
			2: lim <= v;
			3: dflt <= v;
			4: iso <= v;
			5: pos <= v;
			6: eoff <= v;
			7: front <= v[3:0];
			9: prog <= v;
			10: prog_act <= v[0];
			default: di <= v[3:0];
		endcase
	endtask : put
endmodule : sprt_plant_model

// ==== verif/sprt_top_tb.sv ====
// Purpose: self-checking bench for the set-point block
// Assumes: register reads return one cycle after the strobe
// Notes:   all results are read back over the register port and queued
`timescale 1ns/1ps
`include "sprt_consts.svh"
module sprt_top_tb;
	logic               clock     = 1'b0;
	logic               nrst      = 1'b0;
	logic        [7:0]  reg_addr  = 8'h00;
	logic        [15:0] reg_wdata = 16'h0000;
	logic               reg_wr    = 1'b0;
	logic               reg_rd    = 1'b0;
	logic        [15:0] reg_rdata;
	logic signed [15:0] pv, x2, lim, iso, dflt, pos, eoff, prog, eff;
	logic               prog_act, rmp, rd_pend;
	sprt_pkg::sprt_front_s front;
	sprt_pkg::sprt_di_s    di;
	int                 n_fail    = 0;
	int                 n_checks  = 0;
	logic        [15:0] exp_q[$];
	string              name_q[$];
	logic signed [15:0] cur, tgt, pvv;

	always #25 clock = ~clock;

	sprt_plant_model partner_u (.clock(clock), .pv(pv), .x2(x2), .lim(lim), .iso(iso),
		.dflt(dflt), .pos(pos), .eoff(eoff), .prog(prog), .prog_act(prog_act),
		.front(front), .di(di));

	sprt_top dut_u (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .primary_analog_input(pv),
		.second_flow_input(x2), .limit_analog_input(lim), .isolated_analog_input(iso),
		.default_setpoint_input(dflt), .position_feedback_input(pos), .external_offset(eoff),
		.programmer_setpoint(prog), .programmer_active(prog_act), .front_panel(front),
		.control_inputs(di), .effective_setpoint(eff), .control_deviation(),
		.process_value(), .ext_active(), .offset_active(), .bumpless_active(),
		.backup_active(), .ramping(rmp));

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task results;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// ==========================================
	// watcher: read data stand in the cycle after the strobe
	initial rd_pend = 1'b0;
	always @(posedge clock) begin
		if (rd_pend && exp_q.size() > 0)
			check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
		rd_pend <= reg_rd;
	end

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [15:0] e, input string what);
		exp_q.push_back(e);
		name_q.push_back(what);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : rd

	// a switch-over needs up to two ticks, so the bound covers three
	task settle;
		int i;
		repeat (4) @(posedge clock);
		for (i = 0; i < 6500 && rmp !== 1'b0; i++)
			@(posedge clock);
		if (i == 6500) begin
			n_fail++;
			results();
		end
		repeat (3) @(posedge clock);
	endtask : settle

	// waits for the next ramp move, bounded by one tick and a margin, then reads it back
	task next_eff(input logic [15:0] e, input string what);
		int i;
		logic [15:0] old;
		old = eff;
		for (i = 0; i < 2200 && eff === old; i++)
			@(posedge clock);
		if (i == 2200) begin
			n_fail++;
			results();
		end
		repeat (2) @(posedge clock);
		rd(`SPRT_A_EFF, e, what);
	endtask : next_eff

	task ramp_to(input logic signed [15:0] t, input logic signed [15:0] up,
		input logic signed [15:0] dn);
		wr(`SPRT_A_INTSP, t);
		while (cur != t) begin
			if (t > cur)
				cur = (t - cur <= up) ? t : cur + up;
			else
				cur = (cur - t <= dn) ? t : cur - dn;
			next_eff(cur, "ramp step");
		end
	endtask : ramp_to

	initial begin
		void'($urandom(32'h3d7f));
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		rd(`SPRT_A_STOI, `SPRT_R_STOI, "stoich reset");
		rd(8'h3C, 16'h0000, "unmapped");
		// kept above every set-point used, so a pv load always moves the output
		pvv = 16'($urandom_range(1024, 2047));
		partner_u.put(0, pvv);
		partner_u.put(3, 16'h0111);
		partner_u.put(4, 16'h0122);
		partner_u.put(5, 16'h0133);
		wr(`SPRT_A_INTSP, 16'h0100);
		partner_u.put(8, 16'h0008);
		for (int s = 0; s < 3; s++) begin
			wr(`SPRT_A_CFGA, 16'h0004 | 16'(s << 4));
			settle();
			rd(`SPRT_A_EFF, 16'h0111 + 16'(s * 16'h0011), "ext input");
		end
		rd(`SPRT_A_STAT, 16'h0001, "ext status");
		wr(`SPRT_A_CFGA, 16'h0005);
		settle();
		rd(`SPRT_A_EFF, 16'h0100, "int priority");
		wr(`SPRT_A_CFGA, 16'h0004);
		settle();
		wr(`SPRT_A_CFGB, 16'h0020);
		wr(`SPRT_A_CTRL, 16'h0004);
		partner_u.put(8, 16'h0000);
		settle();
		rd(`SPRT_A_INTSP, 16'h0111, "tracked sp");
		rd(`SPRT_A_STAT, 16'h0004, "bumpless status");
		wr(`SPRT_A_INTSP, 16'h0100);
		wr(`SPRT_A_CFGB, 16'h0005);
		wr(`SPRT_A_CTRL, 16'h0002);
		wr(`SPRT_A_INTOFF, 16'h0010);
		settle();
		rd(`SPRT_A_EFF, 16'h0110, "offset add");
		wr(`SPRT_A_CFGA, 16'h0040);
		wr(`SPRT_A_INTOFF, 16'h0200);
		settle();
		rd(`SPRT_A_EFF, 16'h0200, "offset mul");
		wr(`SPRT_A_CTRL, 16'h0000);
		partner_u.put(8, 16'h0008);
		partner_u.put(6, 16'h0020);
		wr(`SPRT_A_CFGA, 16'h0080);
		settle();
		rd(`SPRT_A_EFF, 16'h0120, "offset contact");
		partner_u.put(8, 16'h0000);
		wr(`SPRT_A_CFGB, 16'h0200);
		wr(`SPRT_A_B2SP, 16'h0333);
		wr(`SPRT_A_CTRL, 16'h0008);
		settle();
		rd(`SPRT_A_EFF, 16'h0333, "backup sp");
		wr(`SPRT_A_CTRL, 16'h0000);
		partner_u.put(2, 16'h0300);
		wr(`SPRT_A_CFGA, 16'h0200);
		settle();
		rd(`SPRT_A_EFF, 16'h0300, "clamp min");
		partner_u.put(2, 16'h0050);
		wr(`SPRT_A_CFGA, 16'h0400);
		settle();
		rd(`SPRT_A_EFF, 16'h0050, "clamp max");
		wr(`SPRT_A_CFGA, 16'h0000);
		settle();
		cur = 16'h0100;
		wr(`SPRT_A_GRUP, 16'h0010);
		wr(`SPRT_A_GRDN, 16'h0020);
		ramp_to(16'h0135, 16'h0010, 16'h0020);
		ramp_to(16'h00F0, 16'h0010, 16'h0020);
		rd(`SPRT_A_PV, pvv, "process value");
		rd(`SPRT_A_DEV, pvv - cur, "deviation");
		partner_u.put(1, 16'h0200);
		wr(`SPRT_A_RATK, 16'h0010);
		wr(`SPRT_A_CFGA, 16'h0800);
		repeat (4) @(posedge clock);
		tgt = pvv + 16'h0010 - 16'((32'(cur) * 32'sh0200) >>> 8);
		rd(`SPRT_A_DEV, tgt, "ratio deviation");
		// pv tracking: a bumpless ext->int switch restarts the ramp at the process value
		wr(`SPRT_A_GRDN, 16'h0000);
		wr(`SPRT_A_CFGB, 16'h0020);
		wr(`SPRT_A_CFGA, 16'h0101);
		wr(`SPRT_A_CTRL, 16'h0005);
		settle();
		rd(`SPRT_A_EFF, 16'h0111, "pv to ext");
		wr(`SPRT_A_GRDN, 16'h0020);
		wr(`SPRT_A_CTRL, 16'h0004);
		next_eff(pvv, "pv start");
		next_eff(pvv - 16'h0020, "pv ramp");
		rd(`SPRT_A_INTSP, 16'h00F0, "no sp copy");
		wr(`SPRT_A_GRDN, 16'h0000);
		partner_u.put(9, 16'h0155);
		partner_u.put(10, 16'h0001);
		wr(`SPRT_A_CTRL, 16'h0001);
		settle();
		rd(`SPRT_A_EFF, 16'h0155, "programmer sp");
		partner_u.put(9, 16'h0185);
		next_eff(16'h0165, "programmer step");
		results();
	end
endmodule : sprt_top_tb
